// >>> verilog/sensor_main_config.sv
/*
  Sensor main configuration register with soft reset sequencer.
  Assumes a serial interface engine on mclk that presents register
  accesses as one-cycle strobes and flags the I2C stop condition;
  the SPI chip select and boot strap arrive as raw pins.
*/
// What this block does
// - eight bit register, fields at fixed bits
// - reset values follow boot strap level
// - soft reset accepted in every operating mode
// - writing one starts reset, zero does nothing
// - soft reset reloads defaults, resets functional blocks
// - interrupt polarity, drive, boot disable survive
// - soft reset reinitialises serial interfaces
// - sequence deferred until stop or chip deselect
// - 300 to 500 us before sequence starts
// - reset bit always reads back zero
// - boot completion pulses configured interrupt pin
// - axis selector and polarity steer self-test
// - axis codes: off, X, Y, Z
// - polarity zero positive, one negative
`timescale 1ns/1ns
`default_nettype none
`include "sensor_cfg_regs.svh"

module sensor_main_config
  import sensor_cfg_pkg::*;
#(
  parameter int DELAY_CYC = `RST_DELAY_MIN_CYC,
  parameter int BOOT_CYC  = `BOOT_WAIT_CYC,
  parameter int PULSE_CYC = `BOOT_PULSE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       boot_strap_pin,
  input  wire logic       spi_cs_n,
  input  wire logic       i2c_stop,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       irq_cfg_wr,
  input  wire logic       irq_polarity_in,
  input  wire logic       irq_drive_type_in,
  input  wire logic       boot_disable_in,
  input  wire logic       hibernate_entry,
  output logic [7:0]      reg_rdata,
  output logic [2:0]      selftest_axis_en,
  output logic            selftest_negative,
  output logic            spi_wiring_sel,
  output logic [1:0]      full_scale_range,
  output logic            run_control,
  output logic            func_reset,
  output logic            serial_reinit,
  output logic            irq_polarity,
  output logic            irq_drive_type,
  output logic            boot_disable,
  output logic            irq_pin_out,
  output logic            irq_pin_oe
);

  localparam int CW = $clog2(DELAY_CYC + BOOT_CYC + PULSE_CYC + 2);

  initial begin
    if (DELAY_CYC < 1 || DELAY_CYC > `RST_DELAY_MAX_CYC)
      $error("DELAY_CYC outside the allowed window");
    if (BOOT_CYC < 1 || PULSE_CYC < 1)
      $error("BOOT_CYC and PULSE_CYC must be at least one");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic strap_s;
  logic cs_n_s;

  level_sync u_strap_sync (
    .mclk     (mclk),
    .async_in (boot_strap_pin),
    .sync_out (strap_s)
  );

  level_sync u_cs_sync (
    .mclk     (mclk),
    .async_in (spi_cs_n),
    .sync_out (cs_n_s)
  );

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  soft_rst_state_e state_r, state_nxt;
  logic [6:0]      cfg_r, cfg_nxt;
  logic [7:0]      rdata_nxt;
  logic [7:0]      cfg_default;
  logic            hit_wr;
  logic            hit_rd;
  logic            rst_req;

  assign hit_wr  = reg_wr && (reg_addr == `SENSOR_MAIN_CONFIG_ADDR);
  assign hit_rd  = reg_rd && (reg_addr == `SENSOR_MAIN_CONFIG_ADDR);
  assign rst_req = hit_wr && reg_wdata[`CFG_RST_BIT];

  always_comb begin
    cfg_default = strap_s ? `CFG_RESET_STRAP_HIGH
                          : `CFG_RESET_STRAP_LOW;
    cfg_nxt = cfg_r;
    if (state_r == st_boot)
      cfg_nxt = cfg_default[6:0];
    else if (hit_wr)
      cfg_nxt = reg_wdata[6:0];
    // the trigger bit is not stored, so it always reads as zero
    rdata_nxt = hit_rd ? {1'b0, cfg_r} : 8'h00;
  end

  // sync reset: the strap chain is running, so its level is usable here
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_r     <= cfg_default[6:0];
      reg_rdata <= 8'h00;
    end else begin
      cfg_r     <= cfg_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // retained interrupt settings
  // ----------------------------------------------------------------
  logic [2:0] keep_r, keep_nxt;

  always_comb begin
    keep_nxt = {irq_polarity, irq_drive_type, boot_disable};
    if (hibernate_entry)
      keep_nxt = 3'h0;
    else if (irq_cfg_wr)
      keep_nxt = {irq_polarity_in, irq_drive_type_in, boot_disable_in};
  end

  // only power-on reset or hibernate clears these; soft reset does not
  always_ff @(posedge mclk) begin
    if (sys_rst)
      {irq_polarity, irq_drive_type, boot_disable} <= 3'h0;
    else
      {irq_polarity, irq_drive_type, boot_disable} <= keep_nxt;
  end
  assign keep_r = {irq_polarity, irq_drive_type, boot_disable};

  // ----------------------------------------------------------------
  // soft reset sequencer
  // ----------------------------------------------------------------
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          end_seen_r, end_seen_nxt;
  logic          cs_prev_r;
  logic          xfer_end;
  logic          func_reset_nxt;
  logic          serial_reinit_nxt;
  logic          pulse_nxt;

  // a transaction ends on an I2C stop or a chip select release
  assign xfer_end = i2c_stop || (cs_n_s && !cs_prev_r);

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    end_seen_nxt = end_seen_r;
    case (state_r)
      st_idle: begin
        cnt_nxt      = '0;
        end_seen_nxt = 1'b0;
        // no mode gating: accepted in standby, wake, sleep, trigger
        if (rst_req)
          state_nxt = st_pending;
      end
      st_pending: begin
        if (cnt_r < CW'(DELAY_CYC))
          cnt_nxt = cnt_r + 1'b1;
        end_seen_nxt = end_seen_r || xfer_end;
        if (end_seen_r && cnt_r >= CW'(DELAY_CYC)) begin
          state_nxt = st_boot;
          cnt_nxt   = '0;
        end
      end
      st_boot: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(BOOT_CYC - 1)) begin
          state_nxt = st_notify;
          cnt_nxt   = '0;
        end
      end
      st_notify: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(PULSE_CYC - 1))
          state_nxt = st_idle;
      end
      default: state_nxt = st_idle;
    endcase
    func_reset_nxt    = (state_nxt == st_boot);
    serial_reinit_nxt = (state_nxt == st_boot);
    pulse_nxt         = (state_nxt == st_notify);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r       <= st_idle;
      cnt_r         <= '0;
      end_seen_r    <= 1'b0;
      cs_prev_r     <= 1'b1;
      func_reset    <= 1'b0;
      serial_reinit <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      end_seen_r    <= end_seen_nxt;
      cs_prev_r     <= cs_n_s;
      func_reset    <= func_reset_nxt;
      serial_reinit <= serial_reinit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin and decoded outputs
  // ----------------------------------------------------------------
  logic       irq_out_nxt;
  logic       irq_oe_nxt;
  logic [2:0] axis_nxt;
  logic       neg_nxt;
  logic       st_on;

  assign st_on = (cfg_r[`CFG_ST_AXIS_HI:`CFG_ST_AXIS_LO] != 2'b00);

  always_comb begin
    // polarity one means active high; open drain only drives the level
    irq_out_nxt = pulse_nxt ? irq_polarity : !irq_polarity;
    irq_oe_nxt  = !irq_drive_type || pulse_nxt;
    case (cfg_r[`CFG_ST_AXIS_HI:`CFG_ST_AXIS_LO])
      2'b01:   axis_nxt = 3'b001;
      2'b10:   axis_nxt = 3'b010;
      2'b11:   axis_nxt = 3'b100;
      default: axis_nxt = 3'b000;
    endcase
    neg_nxt = st_on && cfg_r[`CFG_SELFTEST_POLARITY_BIT];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_pin_out       <= 1'b1;
      irq_pin_oe        <= 1'b1;
      selftest_axis_en  <= 3'b000;
      selftest_negative <= 1'b0;
      spi_wiring_sel    <= 1'b0;
      full_scale_range  <= 2'b00;
      run_control       <= 1'b0;
    end else begin
      irq_pin_out       <= irq_out_nxt;
      irq_pin_oe        <= irq_oe_nxt;
      selftest_axis_en  <= axis_nxt;
      selftest_negative <= neg_nxt;
      spi_wiring_sel    <= cfg_r[`CFG_SPI_WIRING_BIT];
      full_scale_range  <= cfg_r[`CFG_FSR_HI:`CFG_FSR_LO];
      run_control       <= cfg_r[`CFG_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence boot_entry_s;
    (state_r == st_pending) ##1 (state_r == st_boot);
  endsequence

  sequence boot_exit_s;
    (state_r == st_boot) ##1 (state_r == st_notify);
  endsequence

  rd_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    hit_rd |=> (reg_rdata == {1'b0, $past(cfg_r)}))
    else $error("register readback wrong or trigger bit not zero");

  strap_reset_a: assert property (@(posedge mclk)
    ($past(sys_rst) && !sys_rst)
      |-> (cfg_r == ($past(strap_s) ? 7'h03 : 7'h00)))
    else $error("reset value does not follow the strap");

  trigger_start_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == st_idle && rst_req) |=> (state_r == st_pending))
    else $error("reset request not taken");

  no_trigger_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == st_idle && !rst_req) |=> (state_r == st_idle))
    else $error("sequencer left idle without request");

  defer_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == st_pending && !end_seen_r) |=> (state_r != st_boot))
    else $error("reset began before the transaction ended");

  delay_min_a: assert property (@(posedge mclk) disable iff (sys_rst)
    boot_entry_s |-> ($past(cnt_r) >= CW'(DELAY_CYC)))
    else $error("reset began before the minimum delay");

  reload_a: assert property (@(posedge mclk) disable iff (sys_rst)
    boot_entry_s |=> (func_reset && serial_reinit
                      && cfg_r == cfg_default[6:0]))
    else $error("boot did not reset blocks and reload defaults");

  keep_bits_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == st_boot && !irq_cfg_wr && !hibernate_entry)
      |=> (keep_r == $past(keep_r)))
    else $error("retained interrupt settings changed by soft reset");

  boot_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
    boot_exit_s |-> (irq_pin_out == irq_polarity && irq_pin_oe))
    else $error("boot completion pulse missing on interrupt pin");

  st_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !st_on |=> (selftest_axis_en == 3'b000 && !selftest_negative))
    else $error("self-test stimulus active while disabled");

endmodule // sensor_main_config

`default_nettype wire

// >>> verilog/sensor_cfg_regs.svh
/*
  Constants for the sensor main configuration register: offset, field
  positions, reset values per boot strap level and timing counts.
  Assumes a 20 MHz system clock; included by bare name.
*/
`ifndef SENSOR_CFG_REGS_SVH
`define SENSOR_CFG_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SENSOR_MAIN_CONFIG_ADDR  8'h15
`define CFG_RST_BIT              7
`define CFG_ST_AXIS_HI           6
`define CFG_ST_AXIS_LO           5
`define CFG_SELFTEST_POLARITY_BIT           4
`define CFG_SPI_WIRING_BIT       3
`define CFG_FSR_HI               2
`define CFG_FSR_LO               1
`define CFG_RUN_BIT              0

// ----------------------------------------------------------------
// reset values (strap grounded / strap at supply)
// ----------------------------------------------------------------
`define CFG_RESET_STRAP_LOW      8'h00
`define CFG_RESET_STRAP_HIGH     8'h03

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_FREQ_MHZ             20
`define RST_DELAY_MIN_US         300
`define RST_DELAY_MAX_US         500
`define RST_DELAY_MIN_CYC        (`RST_DELAY_MIN_US * `CLK_FREQ_MHZ)
`define RST_DELAY_MAX_CYC        (`RST_DELAY_MAX_US * `CLK_FREQ_MHZ)
`define BOOT_WAIT_CYC            32
`define BOOT_PULSE_CYC           4

`endif

// >>> verilog/sensor_cfg_pkg.sv
/*
  Types shared by the sensor configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sensor_cfg_pkg;

  // ----------------------------------------------------------------
  // soft reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle,
    st_pending,
    st_boot,
    st_notify
  } soft_rst_state_e;

endpackage

// >>> verilog/level_sync.sv
/*
  Two flip-flop synchroniser for one asynchronous level.
  Assumes the input is a pin or a signal from another clock.
*/
`timescale 1ns/1ns
`default_nettype none

module level_sync (
  input  wire logic mclk,
  input  wire logic async_in,
  output logic      sync_out
);

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // no reset: the chain must keep tracking the pin while reset is held
  always_ff @(posedge mclk) begin
    meta_r   <= meta_nxt;
    sync_out <= sync_nxt;
  end

endmodule // level_sync

`default_nettype wire

// >>> sim/host_model.sv
/*
  Host serial controller model: register strobes, the I2C stop flag and
  the SPI chip select, all moved just after the falling edge of mclk.
  Assumes the block samples every one of them on the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       i2c_stop,
  output var  logic       spi_cs_n
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    i2c_stop  = 1'b0;
    spi_cs_n  = 1'b1;
  end

  // released address and data show the inverse of the last byte, so a
  // stale value is never mistaken for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask

  task automatic stop();
    @(negedge mclk);
    i2c_stop = 1'b1;
    @(negedge mclk);
    i2c_stop = 1'b0;
  endtask

  task automatic cs(input logic lvl);
    @(negedge mclk);
    spi_cs_n = lvl;
  endtask
endmodule // host_model

`default_nettype wire

// >>> sim/tb_top.sv
/*
  Self-checking bench for the sensor main configuration block.
  Assumes the host model in host_model.sv and small test counts for
  the start delay, boot phase and notification pulse.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import sensor_cfg_pkg::*;
;
  localparam int delay_cyc = 8;
  localparam int boot_cyc  = 4;
  localparam int pulse_cyc = 2;

  logic       mclk, sys_rst, boot_strap_pin, irq_cfg_wr, hibernate_entry;
  logic       irq_polarity_in, irq_drive_type_in, boot_disable_in;
  logic       reg_wr, reg_rd, i2c_stop, spi_cs_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] selftest_axis_en;
  logic [1:0] full_scale_range;
  logic       selftest_negative, spi_wiring_sel, run_control, func_reset;
  logic       serial_reinit, irq_polarity, irq_drive_type, boot_disable;
  logic       irq_pin_out, irq_pin_oe;
  int         n_errors = 0;
  int         checks   = 0;
  int         cycles   = 0;

  host_model host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .i2c_stop(i2c_stop), .spi_cs_n(spi_cs_n));

  sensor_main_config #(.DELAY_CYC(delay_cyc), .BOOT_CYC(boot_cyc),
    .PULSE_CYC(pulse_cyc)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .boot_strap_pin(boot_strap_pin), .spi_cs_n(spi_cs_n),
    .i2c_stop(i2c_stop), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .irq_cfg_wr(irq_cfg_wr),
    .irq_polarity_in(irq_polarity_in), .irq_drive_type_in(irq_drive_type_in),
    .boot_disable_in(boot_disable_in), .hibernate_entry(hibernate_entry),
    .reg_rdata(reg_rdata), .selftest_axis_en(selftest_axis_en),
    .selftest_negative(selftest_negative), .spi_wiring_sel(spi_wiring_sel),
    .full_scale_range(full_scale_range), .run_control(run_control),
    .func_reset(func_reset), .serial_reinit(serial_reinit),
    .irq_polarity(irq_polarity), .irq_drive_type(irq_drive_type),
    .boot_disable(boot_disable), .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe));

  // ----------------------------------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, lo);
    end
  endtask

  // expected decode is worked out here from the written byte
  task automatic chk_out(input logic [7:0] c);
    logic [2:0] ax;
    ax = (c[6:5] == 2'b00) ? 3'b000 : 3'b001 << (c[6:5] - 2'd1);
    chk({5'h00, selftest_axis_en}, {5'h00, ax});
    chk({7'h00, selftest_negative}, {7'h00, c[4] & |c[6:5]});
    chk({4'h0, spi_wiring_sel, full_scale_range, run_control},
        {4'h0, c[3:0]});
  endtask

  task automatic do_reset();
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
  endtask

  // waits for the boot phase and the completion pulse, then checks the
  // reload; no access is made before the pulse has been seen
  task automatic boot_check(output int n, input logic [7:0] dflt);
    logic [7:0] r;
    int         len;
    n = 0;
    while (func_reset !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk({7'h00, serial_reinit}, 8'h01);
    len = 0;
    while (func_reset === 1'b1 && len < 40) begin
      @(negedge mclk);
      len++;
    end
    chk_cnt(len, boot_cyc, boot_cyc);
    len = 0;
    while (irq_pin_out !== irq_polarity && len < 6) begin
      @(negedge mclk);
      len++;
    end
    chk({7'h00, irq_pin_oe}, 8'h01);
    len = 0;
    while (irq_pin_out === irq_polarity && len < 10) begin
      @(negedge mclk);
      len++;
    end
    chk_cnt(len, pulse_cyc, pulse_cyc);
    host.rd(8'h15, r);
    chk(r, dflt);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    logic [7:0] r;
    host.rd(8'h15, r);
    chk(r, 8'h00);
    chk_out(8'h00);
    chk({5'h00, irq_polarity, irq_drive_type, boot_disable}, 8'h00);
    chk({6'h00, irq_pin_oe, irq_pin_out}, 8'h03);
    $display("test defaults done");
  endtask

  task automatic t_fields();
    logic [7:0] r;
    logic [7:0] d;
    for (int k = 0; k < 8; k++) begin
      d = {1'b0, k[2:0], ~k[2:0], k[0]};
      host.wr(8'h15, d);
      @(negedge mclk);
      chk_out(d);
      host.rd(8'h15, r);
      chk(r, d);
    end
    host.wr(8'h16, 8'h55);
    host.rd(8'h15, r);
    chk(r, d);
    host.rd(8'h16, r);
    chk(r, 8'h00);
    $display("test fields done");
  endtask

  task automatic t_soft_i2c();
    logic [7:0] r;
    int         n;
    irq_polarity_in   = 1'b1;
    irq_drive_type_in = 1'b1;
    boot_disable_in   = 1'b1;
    irq_cfg_wr        = 1'b1;
    @(negedge mclk);
    irq_cfg_wr = 1'b0;
    @(negedge mclk);
    chk({6'h00, irq_pin_oe, irq_pin_out}, 8'h00);
    host.wr(8'h15, 8'h00);
    repeat (12) @(negedge mclk);
    host.stop();
    repeat (4) @(negedge mclk);
    chk({7'h00, func_reset}, 8'h00);
    host.wr(8'h15, 8'hAA);
    host.rd(8'h15, r);
    chk(r, 8'h2A);
    repeat (20) @(negedge mclk);
    chk({7'h00, func_reset}, 8'h00);
    host.stop();
    boot_check(n, 8'h00);
    chk({5'h00, irq_polarity, irq_drive_type, boot_disable}, 8'h07);
    hibernate_entry = 1'b1;
    @(negedge mclk);
    hibernate_entry = 1'b0;
    @(negedge mclk);
    chk({5'h00, irq_polarity, irq_drive_type, boot_disable}, 8'h00);
    $display("test soft reset i2c done");
  endtask

  task automatic t_soft_spi();
    int n;
    host.cs(1'b0);
    host.wr(8'h15, 8'hA5);
    repeat (20) @(negedge mclk);
    chk({7'h00, func_reset}, 8'h00);
    host.cs(1'b1);
    boot_check(n, 8'h00);
    chk_cnt(n, 1, 8);
    $display("test soft reset spi done");
  endtask

  task automatic t_delay();
    int n;
    host.wr(8'h15, 8'h81);
    host.stop();
    boot_check(n, 8'h00);
    chk_cnt(n + 2, delay_cyc, delay_cyc * 5 / 3 + 3);
    $display("test start delay done");
  endtask

  task automatic t_strap();
    logic [7:0] r;
    int         n;
    boot_strap_pin = 1'b1;
    do_reset();
    host.rd(8'h15, r);
    chk(r, 8'h03);
    chk_out(8'h03);
    host.wr(8'h15, 8'hF8);
    host.stop();
    boot_check(n, 8'h03);
    $display("test strap high done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst           = 1'b1;
    boot_strap_pin    = 1'b0;
    irq_cfg_wr        = 1'b0;
    irq_polarity_in   = 1'b0;
    irq_drive_type_in = 1'b0;
    boot_disable_in   = 1'b0;
    hibernate_entry   = 1'b0;
    do_reset();
    t_defaults();
    t_fields();
    t_soft_i2c();
    t_soft_spi();
    t_delay();
    t_strap();
    results();
  end
endmodule // tb_top

`default_nettype wire
